// *** design/ofs_params.svh ***
/*
 * Constants for the output terminal function selector: function codes, widths and timing.
 * Assumes inclusion by its bare name from every file that needs a constant.
 */
`ifndef OFS_PARAMS_SVH
`define OFS_PARAMS_SVH

`define OFS_NUM_TERMS 5
`define OFS_CODE_W 6
`define OFS_VAL_W 16
`define OFS_NUM_CODES 41
`define OFS_LOW_CODES 9

`define OFS_CODE_NONE 6'h00
`define OFS_CODE_LOW_FIRST 6'h01
`define OFS_CODE_LENGTH 6'h0A
`define OFS_CODE_PLC_CYCLE 6'h0B
`define OFS_CODE_RUN_TIME 6'h0C
`define OFS_CODE_FREQ_LIMITED 6'h0D
`define OFS_CODE_TORQUE_LIMITED 6'h0E
`define OFS_CODE_READY 6'h0F
`define OFS_CODE_AI_GREATER 6'h10
`define OFS_CODE_UPPER_REACHED 6'h11
`define OFS_CODE_LOWER_STOP_OFF 6'h12
`define OFS_CODE_UNDERVOLTAGE 6'h13
`define OFS_CODE_COMM 6'h14
`define OFS_CODE_RSVD_A 6'h15
`define OFS_CODE_RSVD_B 6'h16
`define OFS_CODE_ZERO_SPEED_2 6'h17
`define OFS_CODE_POWER_ON_TIME 6'h18
`define OFS_CODE_FREQ_LEVEL_2 6'h19
`define OFS_CODE_FREQ_1_REACHED 6'h1A
`define OFS_CODE_FREQ_2_REACHED 6'h1B
`define OFS_CODE_CURR_1_REACHED 6'h1C
`define OFS_CODE_CURR_2_REACHED 6'h1D
`define OFS_CODE_TIMING 6'h1E
`define OFS_CODE_AI_LIMIT 6'h1F
`define OFS_CODE_LOAD_ZERO 6'h20
`define OFS_CODE_REVERSE 6'h21
`define OFS_CODE_ZERO_CURRENT 6'h22
`define OFS_CODE_MODULE_TEMP 6'h23
`define OFS_CODE_SW_CURR_LIMIT 6'h24
`define OFS_CODE_LOWER_STOP_ON 6'h25
`define OFS_CODE_ALARM 6'h26
`define OFS_CODE_MOTOR_TEMP 6'h27
`define OFS_CODE_CURR_RUN_TIME 6'h28
`define OFS_CODE_MAX 6'h28

`define OFS_VAL_ZERO 16'h0000
`define OFS_PLC_PULSE_MS 250
`define OFS_CLK_KHZ 125000
`define OFS_PULSE_CW 25
`define OFS_PULSE_CNT_ZERO 25'h0000000

`endif

// *** design/ofs_pkg.sv ***
/*
 * Types shared by the output terminal function selector modules.
 * Assumes the constants header is on the include path.
 */
`default_nettype none
`include "ofs_params.svh"

package ofs_pkg;
    typedef logic [`OFS_CODE_W-1:0] ofs_code_t;
    typedef logic [`OFS_VAL_W-1:0] ofs_val_t;
    typedef logic [`OFS_NUM_TERMS-1:0][`OFS_CODE_W-1:0] ofs_sel_arr_t;
    typedef logic [`OFS_NUM_CODES-1:0] ofs_cond_t;
    typedef enum logic {
        OFS_PULSE_IDLE = 1'b0,
        OFS_PULSE_ACTIVE = 1'b1
    } ofs_pulse_state_t;
endpackage : ofs_pkg

`default_nettype wire

// *** design/ofs_pulse.sv ***
/*
 * One-shot pulse stretcher: a start strobe produces an active level lasting PULSE_CYCLES clocks.
 * Assumes start is a one-cycle strobe from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ofs_params.svh"

module ofs_pulse #(
    parameter int PULSE_CYCLES = `OFS_PLC_PULSE_MS * `OFS_CLK_KHZ
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic start,
    output logic active
);
    import ofs_pkg::*;

    ofs_pulse_state_t state_ff;
    logic [`OFS_PULSE_CW-1:0] cnt_ff;

    // A new strobe during a pulse restarts the full width.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_ff <= OFS_PULSE_IDLE;
            cnt_ff <= `OFS_PULSE_CNT_ZERO;
        end else if (start) begin
            state_ff <= OFS_PULSE_ACTIVE;
            cnt_ff <= `OFS_PULSE_CW'(PULSE_CYCLES - 1);
        end else begin
            case (state_ff)
                OFS_PULSE_IDLE: begin
                    cnt_ff <= `OFS_PULSE_CNT_ZERO;
                end
                OFS_PULSE_ACTIVE: begin
                    if (cnt_ff == `OFS_PULSE_CNT_ZERO) begin
                        state_ff <= OFS_PULSE_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff - `OFS_PULSE_CW'(1);
                    end
                end
                default: begin
                    state_ff <= OFS_PULSE_IDLE;
                end
            endcase
        end
    end

    assign active = (state_ff == OFS_PULSE_ACTIVE);
endmodule // ofs_pulse

`default_nettype wire

// *** design/ofs_sel.sv ***
/*
 * One output terminal: picks the condition named by its function code and registers it.
 * Assumes the condition vector is registered and indexed by function code.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ofs_params.svh"

module ofs_sel (
    input wire logic clk,
    input wire logic resetn,
    input wire ofs_pkg::ofs_code_t sel,
    input wire ofs_pkg::ofs_cond_t cond,
    output logic term
);
    import ofs_pkg::*;

    logic term_ff;
    logic nxt_term;

    // True for codes that name a defined condition.
    function automatic logic code_defined(input ofs_code_t code);
        code_defined = (code != `OFS_CODE_NONE) && (code <= `OFS_CODE_MAX) &&
                       (code != `OFS_CODE_RSVD_A) && (code != `OFS_CODE_RSVD_B);
    endfunction

    always_comb begin
        nxt_term = 1'b0;
        if (code_defined(sel)) begin
            nxt_term = cond[sel];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            term_ff <= 1'b0;
        end else begin
            term_ff <= nxt_term;
        end
    end

    assign term = term_ff;
endmodule // ofs_sel

`default_nettype wire

// *** design/ofs_top.sv ***
/*
 * Output terminal function selector for a motor drive: builds every selectable condition
 * for function codes 10 to 40, routes codes 1 to 9 from outside, and drives five terminals.
 * Assumes all status flags and measured values come from drive-core logic on CLK, and
 * that polarity inversion and output delay are applied downstream of TERM_OUT.
 */
//
// Contract
// - Each terminal has its own selector; code 0 keeps it off.
// - Code 10 on when actual length exceeds target length.
// - Code 11 gives one 250 ms pulse per completed PLC cycle; here a cycle ending mid-pulse restarts and extends that pulse instead.
// - Code 12 on when accumulated running time exceeds its threshold.
// - Code 13 on when set frequency beyond a limit and output reached it.
// - Code 14 on in speed control while torque has reached the limit.
// - Code 15 on when circuits stable, no fault, and ready to run.
// - Code 16 on while first analog input exceeds the second.
// - Code 17 on when running frequency reaches upper limit.
// - Codes 18/37 on at lower limit; at stop 18 off, 37 on.
// - Code 19 on while in undervoltage.
// - Code 20 follows the host-written value; codes 21, 22 reserved.
// - Code 23 on when output frequency is zero or drive stopped.
// - Code 24 on when power-on time counter exceeds its threshold.
// - Codes 25-29, 34, 36 route the matching detector flags.
// - Code 30 on when timing enabled and run time reaches timing value.
// - Code 31 on when first analog input leaves its bounds.
// - Code 32 on when detected motor load is zero.
// - Code 33 on while running in reverse.
// - Code 35 on when heatsink temperature reaches module threshold.
// - Code 38 on when a fault is present while still running.
// - Code 39 on when motor temperature reaches overheat threshold.
// - Code 40 on when current run time exceeds its threshold.
`timescale 1ns/1ps
`default_nettype none
`include "ofs_params.svh"

module ofs_top #(
    parameter int PLC_PULSE_CYCLES = `OFS_PLC_PULSE_MS * `OFS_CLK_KHZ
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire ofs_pkg::ofs_sel_arr_t TERM_SEL,
    input wire logic [`OFS_LOW_CODES-1:0] LOW_FUNC_COND,
    input wire logic [`OFS_NUM_TERMS-1:0] COMM_TERM_VALUE,
    input wire logic RUNNING,
    input wire logic REVERSE_RUNNING,
    input wire logic SPEED_CONTROL_MODE,
    input wire logic FAULT_PRESENT,
    input wire logic MAIN_CIRCUIT_STABLE,
    input wire logic CONTROL_CIRCUIT_STABLE,
    input wire logic DRIVE_READY,
    input wire logic UNDERVOLTAGE,
    input wire logic PLC_CYCLE_DONE,
    input wire logic TIMING_FUNCTION_ENABLE,
    input wire logic SECOND_FREQUENCY_LEVEL_DETECT,
    input wire logic FREQ_1_REACHED,
    input wire logic FREQ_2_REACHED,
    input wire logic CURRENT_1_REACHED,
    input wire logic CURRENT_2_REACHED,
    input wire logic ZERO_CURRENT,
    input wire logic SW_CURRENT_LIMIT,
    input wire ofs_pkg::ofs_val_t ACTUAL_LENGTH,
    input wire ofs_pkg::ofs_val_t TARGET_LENGTH_SETTING,
    input wire ofs_pkg::ofs_val_t ACCUM_RUNNING_TIME,
    input wire ofs_pkg::ofs_val_t RUNNING_TIME_THRESHOLD,
    input wire ofs_pkg::ofs_val_t SET_FREQ,
    input wire ofs_pkg::ofs_val_t OUTPUT_FREQ,
    input wire ofs_pkg::ofs_val_t RUN_FREQ,
    input wire ofs_pkg::ofs_val_t FREQ_UPPER_LIMIT,
    input wire ofs_pkg::ofs_val_t FREQ_LOWER_LIMIT,
    input wire ofs_pkg::ofs_val_t OUTPUT_TORQUE,
    input wire ofs_pkg::ofs_val_t TORQUE_LIMIT,
    input wire ofs_pkg::ofs_val_t ANALOG_INPUT_FIRST,
    input wire ofs_pkg::ofs_val_t ANALOG_INPUT_SECOND,
    input wire ofs_pkg::ofs_val_t ANALOG_FIRST_LOWER_BOUND,
    input wire ofs_pkg::ofs_val_t ANALOG_FIRST_UPPER_BOUND,
    input wire ofs_pkg::ofs_val_t POWER_ON_TIME_COUNTER,
    input wire ofs_pkg::ofs_val_t POWER_ON_TIME_THRESHOLD,
    input wire ofs_pkg::ofs_val_t CURRENT_RUN_TIME,
    input wire ofs_pkg::ofs_val_t TIMING_VALUE,
    input wire ofs_pkg::ofs_val_t CURRENT_RUN_TIME_THRESHOLD,
    input wire ofs_pkg::ofs_val_t MOTOR_LOAD,
    input wire ofs_pkg::ofs_val_t HEATSINK_TEMPERATURE_VALUE,
    input wire ofs_pkg::ofs_val_t MODULE_TEMPERATURE_THRESHOLD,
    input wire ofs_pkg::ofs_val_t MOTOR_TEMPERATURE_MONITOR,
    input wire ofs_pkg::ofs_val_t MOTOR_OVERHEAT_THRESHOLD,
    output logic [`OFS_NUM_TERMS-1:0] TERM_OUT
);
    import ofs_pkg::*;

    ofs_cond_t cond_ff;
    ofs_cond_t nxt_cond;
    logic [`OFS_NUM_TERMS-1:0] comm_ff;
    logic plc_pulse;
    logic freq_at_lower;
    logic freq_limited;

    // The PLC strobe is stretched to a retriggerable pulse shared by all terminals.
    ofs_pulse #(
        .PULSE_CYCLES(PLC_PULSE_CYCLES)
    ) u_plc_pulse (
        .clk(CLK),
        .resetn(RESETN),
        .start(PLC_CYCLE_DONE),
        .active(plc_pulse)
    );

    // The host value is held per terminal and sampled alongside the conditions.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            comm_ff <= '0;
        end else begin
            comm_ff <= COMM_TERM_VALUE;
        end
    end

    assign freq_at_lower = (RUN_FREQ <= FREQ_LOWER_LIMIT);

    // A limit only counts as limiting when the request lies beyond it.
    assign freq_limited =
        ((SET_FREQ > FREQ_UPPER_LIMIT) && (OUTPUT_FREQ >= FREQ_UPPER_LIMIT)) ||
        ((SET_FREQ < FREQ_LOWER_LIMIT) && (OUTPUT_FREQ <= FREQ_LOWER_LIMIT));

    always_comb begin
        nxt_cond = '0;
        nxt_cond[`OFS_CODE_NONE] = 1'b0;
        nxt_cond[`OFS_CODE_LOW_FIRST +: `OFS_LOW_CODES] = LOW_FUNC_COND;
        nxt_cond[`OFS_CODE_LENGTH] = (ACTUAL_LENGTH > TARGET_LENGTH_SETTING);
        nxt_cond[`OFS_CODE_PLC_CYCLE] = plc_pulse;
        nxt_cond[`OFS_CODE_RUN_TIME] = (ACCUM_RUNNING_TIME > RUNNING_TIME_THRESHOLD);
        nxt_cond[`OFS_CODE_FREQ_LIMITED] = freq_limited;
        nxt_cond[`OFS_CODE_TORQUE_LIMITED] =
            SPEED_CONTROL_MODE && (OUTPUT_TORQUE >= TORQUE_LIMIT);
        nxt_cond[`OFS_CODE_READY] = MAIN_CIRCUIT_STABLE && CONTROL_CIRCUIT_STABLE &&
                                    !FAULT_PRESENT && DRIVE_READY;
        nxt_cond[`OFS_CODE_AI_GREATER] = (ANALOG_INPUT_FIRST > ANALOG_INPUT_SECOND);
        nxt_cond[`OFS_CODE_UPPER_REACHED] = (RUN_FREQ >= FREQ_UPPER_LIMIT);
        nxt_cond[`OFS_CODE_LOWER_STOP_OFF] = RUNNING && freq_at_lower;
        nxt_cond[`OFS_CODE_LOWER_STOP_ON] = !RUNNING || freq_at_lower;
        nxt_cond[`OFS_CODE_UNDERVOLTAGE] = UNDERVOLTAGE;
        nxt_cond[`OFS_CODE_RSVD_A] = 1'b0;
        nxt_cond[`OFS_CODE_RSVD_B] = 1'b0;
        nxt_cond[`OFS_CODE_ZERO_SPEED_2] = (OUTPUT_FREQ == `OFS_VAL_ZERO) || !RUNNING;
        nxt_cond[`OFS_CODE_POWER_ON_TIME] =
            (POWER_ON_TIME_COUNTER > POWER_ON_TIME_THRESHOLD);
        nxt_cond[`OFS_CODE_FREQ_LEVEL_2] = SECOND_FREQUENCY_LEVEL_DETECT;
        nxt_cond[`OFS_CODE_FREQ_1_REACHED] = FREQ_1_REACHED;
        nxt_cond[`OFS_CODE_FREQ_2_REACHED] = FREQ_2_REACHED;
        nxt_cond[`OFS_CODE_CURR_1_REACHED] = CURRENT_1_REACHED;
        nxt_cond[`OFS_CODE_CURR_2_REACHED] = CURRENT_2_REACHED;
        nxt_cond[`OFS_CODE_ZERO_CURRENT] = ZERO_CURRENT;
        nxt_cond[`OFS_CODE_SW_CURR_LIMIT] = SW_CURRENT_LIMIT;
        nxt_cond[`OFS_CODE_TIMING] =
            TIMING_FUNCTION_ENABLE && (CURRENT_RUN_TIME >= TIMING_VALUE);
        nxt_cond[`OFS_CODE_AI_LIMIT] = (ANALOG_INPUT_FIRST > ANALOG_FIRST_UPPER_BOUND) ||
                                       (ANALOG_INPUT_FIRST < ANALOG_FIRST_LOWER_BOUND);
        nxt_cond[`OFS_CODE_LOAD_ZERO] = (MOTOR_LOAD == `OFS_VAL_ZERO);
        nxt_cond[`OFS_CODE_REVERSE] = RUNNING && REVERSE_RUNNING;
        nxt_cond[`OFS_CODE_MODULE_TEMP] =
            (HEATSINK_TEMPERATURE_VALUE >= MODULE_TEMPERATURE_THRESHOLD);
        nxt_cond[`OFS_CODE_ALARM] = FAULT_PRESENT && RUNNING;
        nxt_cond[`OFS_CODE_MOTOR_TEMP] =
            (MOTOR_TEMPERATURE_MONITOR >= MOTOR_OVERHEAT_THRESHOLD);
        nxt_cond[`OFS_CODE_CURR_RUN_TIME] =
            (CURRENT_RUN_TIME > CURRENT_RUN_TIME_THRESHOLD);
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            cond_ff <= '0;
        end else begin
            cond_ff <= nxt_cond;
        end
    end

    // Each terminal sees the common conditions, with its own host value patched in.
    genvar gi;
    generate
        for (gi = 0; gi < `OFS_NUM_TERMS; gi++) begin : g_term
            ofs_cond_t term_cond;

            always_comb begin
                term_cond = cond_ff;
                term_cond[`OFS_CODE_COMM] = comm_ff[gi];
            end

            ofs_sel u_sel (
                .clk(CLK),
                .resetn(RESETN),
                .sel(TERM_SEL[gi]),
                .cond(term_cond),
                .term(TERM_OUT[gi])
            );
        end
    endgenerate
endmodule // ofs_top

`default_nettype wire

// *** sim/ofs_top_asserts.sv ***
/*
 * Checker for the output terminal selector, watching terminal 0 only.
 * Assumes it is bound into ofs_top and that every input is on CLK.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ofs_params.svh"

module ofs_chk (
    input wire logic CLK,
    input wire logic RESETN,
    input wire ofs_pkg::ofs_sel_arr_t TERM_SEL,
    input wire logic [`OFS_NUM_TERMS-1:0] COMM_TERM_VALUE,
    input wire logic RUNNING,
    input wire logic REVERSE_RUNNING,
    input wire logic FAULT_PRESENT,
    input wire logic PLC_CYCLE_DONE,
    input wire ofs_pkg::ofs_val_t ACTUAL_LENGTH,
    input wire ofs_pkg::ofs_val_t TARGET_LENGTH_SETTING,
    input wire ofs_pkg::ofs_val_t OUTPUT_FREQ,
    input wire ofs_pkg::ofs_val_t RUN_FREQ,
    input wire ofs_pkg::ofs_val_t FREQ_LOWER_LIMIT,
    input wire ofs_pkg::ofs_val_t ANALOG_INPUT_FIRST,
    input wire ofs_pkg::ofs_val_t ANALOG_INPUT_SECOND,
    input wire ofs_pkg::ofs_val_t HEATSINK_TEMPERATURE_VALUE,
    input wire ofs_pkg::ofs_val_t MODULE_TEMPERATURE_THRESHOLD,
    input wire logic [`OFS_NUM_TERMS-1:0] TERM_OUT
);
    import ofs_pkg::*;
    logic [2:0] up_ff;
    ofs_code_t s0;
    assign s0 = TERM_SEL[0];
    // Bit n says reset has been released for at least n+1 edges, so history can be trusted.
    always_ff @(posedge CLK) begin
        up_ff <= RESETN ? {up_ff[1:0], 1'b1} : 3'h0;
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    a_idle_codes:
    assert property (up_ff[0] && (s0 == `OFS_CODE_NONE || s0 == `OFS_CODE_RSVD_A
        || s0 == `OFS_CODE_RSVD_B || s0 > `OFS_CODE_MAX) |=> !TERM_OUT[0])
        else $error("terminal on with an idle code");
    a_length_hit:
    assert property (up_ff[0] && s0 == `OFS_CODE_LENGTH |=> TERM_OUT[0]
        == ($past(ACTUAL_LENGTH, 2) > $past(TARGET_LENGTH_SETTING, 2))) else $error("length");
    a_plc_pulse:
    assert property (up_ff[2] && $past(PLC_CYCLE_DONE, 3) && $past(s0) == `OFS_CODE_PLC_CYCLE
        |-> TERM_OUT[0]) else $error("cycle pulse missing");
    a_ai_compare:
    assert property (up_ff[0] && s0 == `OFS_CODE_AI_GREATER |=> TERM_OUT[0]
        == ($past(ANALOG_INPUT_FIRST, 2) > $past(ANALOG_INPUT_SECOND, 2))) else $error("ai");
    a_lower_noout:
    assert property (up_ff[0] && s0 == `OFS_CODE_LOWER_STOP_OFF |=> TERM_OUT[0]
        == ($past(RUNNING, 2) && $past(RUN_FREQ, 2) <= $past(FREQ_LOWER_LIMIT, 2)))
        else $error("lower limit");
    a_comm_follow:
    assert property (up_ff[0] && s0 == `OFS_CODE_COMM |=> TERM_OUT[0]
        == $past(COMM_TERM_VALUE[0], 2)) else $error("host value");
    a_zero_speed:
    assert property (up_ff[0] && s0 == `OFS_CODE_ZERO_SPEED_2 |=> TERM_OUT[0]
        == ($past(OUTPUT_FREQ, 2) == 16'h0000 || !$past(RUNNING, 2))) else $error("zero speed");
    a_reverse_run:
    assert property (up_ff[0] && s0 == `OFS_CODE_REVERSE |=> TERM_OUT[0]
        == ($past(RUNNING, 2) && $past(REVERSE_RUNNING, 2))) else $error("reverse");
    a_module_hot:
    assert property (up_ff[0] && s0 == `OFS_CODE_MODULE_TEMP |=> TERM_OUT[0]
        == ($past(HEATSINK_TEMPERATURE_VALUE, 2) >= $past(MODULE_TEMPERATURE_THRESHOLD, 2)))
        else $error("module temperature");
    a_alarm_run:
    assert property (up_ff[0] && s0 == `OFS_CODE_ALARM |=> TERM_OUT[0]
        == ($past(FAULT_PRESENT, 2) && $past(RUNNING, 2))) else $error("alarm");
endmodule // ofs_chk

bind ofs_top ofs_chk u_chk (.*);
`default_nettype wire

// *** sim/ofs_term_drv.sv ***
/*
 * Model of the relay and open-collector drivers behind the terminals, with a width meter.
 * Assumes terminal states change only just after rising clk edges.
 */
`timescale 1ns/1ps
`default_nettype none

module ofs_term_drv (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [4:0] term,
    output logic [4:0] pin,
    output logic [31:0] hi_len
);
    logic [31:0] cnt_ff;
    // Pins follow one edge late; hi_len keeps the last finished high run of terminal 0.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pin <= 5'h00;
            cnt_ff <= 32'h0;
            hi_len <= 32'h0;
        end else begin
            pin <= term;
            cnt_ff <= term[0] ? cnt_ff + 32'h1 : 32'h0;
            if (!term[0] && cnt_ff != 32'h0) begin
                hi_len <= cnt_ff;
            end
        end
    end
endmodule // ofs_term_drv
`default_nettype wire

// *** sim/ofs_tb.sv ***
/*
 * Bench for ofs_top: random traffic against a cycle model, pulse widths, mid-run reset.
 * Assumes the design, the checker and the driver model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ofs_params.svh"

module tb;
    import ofs_pkg::*;
    localparam int P = 20;
    logic CLK, RESETN, PLC_CYCLE_DONE;
    ofs_sel_arr_t TERM_SEL;
    logic [`OFS_LOW_CODES-1:0] LOW_FUNC_COND;
    logic [`OFS_NUM_TERMS-1:0] COMM_TERM_VALUE, TERM_OUT, pin, ex, qc, exd;
    logic RUNNING, REVERSE_RUNNING, SPEED_CONTROL_MODE, FAULT_PRESENT, MAIN_CIRCUIT_STABLE;
    logic CONTROL_CIRCUIT_STABLE, DRIVE_READY, UNDERVOLTAGE, TIMING_FUNCTION_ENABLE;
    logic SECOND_FREQUENCY_LEVEL_DETECT, FREQ_1_REACHED, FREQ_2_REACHED, CURRENT_1_REACHED;
    logic CURRENT_2_REACHED, ZERO_CURRENT, SW_CURRENT_LIMIT;
    ofs_val_t ACTUAL_LENGTH, TARGET_LENGTH_SETTING, ACCUM_RUNNING_TIME, RUNNING_TIME_THRESHOLD;
    ofs_val_t SET_FREQ, OUTPUT_FREQ, RUN_FREQ, FREQ_UPPER_LIMIT, FREQ_LOWER_LIMIT, OUTPUT_TORQUE;
    ofs_val_t TORQUE_LIMIT, ANALOG_INPUT_FIRST, ANALOG_INPUT_SECOND, ANALOG_FIRST_LOWER_BOUND;
    ofs_val_t ANALOG_FIRST_UPPER_BOUND, POWER_ON_TIME_COUNTER, POWER_ON_TIME_THRESHOLD;
    ofs_val_t CURRENT_RUN_TIME, TIMING_VALUE, CURRENT_RUN_TIME_THRESHOLD, MOTOR_LOAD;
    ofs_val_t HEATSINK_TEMPERATURE_VALUE, MODULE_TEMPERATURE_THRESHOLD;
    ofs_val_t MOTOR_TEMPERATURE_MONITOR, MOTOR_OVERHEAT_THRESHOLD;
    logic [15:0] flg;
    logic [24:0][15:0] vals;
    logic [63:0] q;
    logic [31:0] hi_len;
    integer seed = 32'h3D6609C8;
    int miscompares, n_checks, pcnt, go;
    assign {RUNNING, REVERSE_RUNNING, SPEED_CONTROL_MODE, FAULT_PRESENT, MAIN_CIRCUIT_STABLE,
        CONTROL_CIRCUIT_STABLE, DRIVE_READY, UNDERVOLTAGE, TIMING_FUNCTION_ENABLE,
        SECOND_FREQUENCY_LEVEL_DETECT, FREQ_1_REACHED, FREQ_2_REACHED, CURRENT_1_REACHED,
        CURRENT_2_REACHED, ZERO_CURRENT, SW_CURRENT_LIMIT} = flg;
    assign {ACTUAL_LENGTH, TARGET_LENGTH_SETTING, ACCUM_RUNNING_TIME, RUNNING_TIME_THRESHOLD,
        SET_FREQ, OUTPUT_FREQ, RUN_FREQ, FREQ_UPPER_LIMIT, FREQ_LOWER_LIMIT, OUTPUT_TORQUE,
        TORQUE_LIMIT, ANALOG_INPUT_FIRST, ANALOG_INPUT_SECOND, ANALOG_FIRST_LOWER_BOUND,
        ANALOG_FIRST_UPPER_BOUND, POWER_ON_TIME_COUNTER, POWER_ON_TIME_THRESHOLD,
        CURRENT_RUN_TIME, TIMING_VALUE, CURRENT_RUN_TIME_THRESHOLD, MOTOR_LOAD,
        HEATSINK_TEMPERATURE_VALUE, MODULE_TEMPERATURE_THRESHOLD,
        MOTOR_TEMPERATURE_MONITOR, MOTOR_OVERHEAT_THRESHOLD} = vals;

    ofs_top #(.PLC_PULSE_CYCLES(P)) dut (.*);
    ofs_term_drv u_drv (.clk(CLK), .resetn(RESETN), .term(TERM_OUT), .pin(pin), .hi_len(hi_len));

    initial begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end

    function automatic int v(int i);
        return int'(vals[24-i]);
    endfunction
    function automatic bit f(int i);
        return flg[15-i];
    endfunction
    // Condition behind each function code, from the values seen before the edge.
    function automatic bit cnd(int c);
        case (c)
            10: return v(0) > v(1);
            11: return pcnt > 0;
            12: return v(2) > v(3);
            13: return (v(4) > v(7) && v(5) >= v(7)) || (v(4) < v(8) && v(5) <= v(8));
            14: return f(2) && v(9) >= v(10);
            15: return f(4) && f(5) && !f(3) && f(6);
            16: return v(11) > v(12);
            17: return v(6) >= v(7);
            18: return f(0) && v(6) <= v(8);
            19: return f(7);
            23: return v(5) == 0 || !f(0);
            24: return v(15) > v(16);
            25, 26, 27, 28, 29: return f(c - 16);
            30: return f(8) && v(17) >= v(18);
            31: return v(11) > v(14) || v(11) < v(13);
            32: return v(20) == 0;
            33: return f(0) && f(1);
            34: return f(14);
            35: return v(21) >= v(22);
            36: return f(15);
            37: return !f(0) || v(6) <= v(8);
            38: return f(3) && f(0);
            39: return v(23) >= v(24);
            40: return v(17) > v(19);
            default: return c >= 1 && c <= 9 && LOW_FUNC_COND[c-1] === 1'b1;
        endcase
    endfunction

    always @(posedge CLK) begin
        if (!RESETN) begin
            q <= '0;
            qc <= '0;
            ex <= '0;
            exd <= '0;
            pcnt = 0;
        end else begin
            for (int g = 0; g < 5; g++)
                ex[g] <= (TERM_SEL[g] == 6'h14) ? qc[g] : q[TERM_SEL[g]];
            for (int c = 0; c < 64; c++)
                q[c] <= cnd(c);
            qc <= COMM_TERM_VALUE;
            exd <= ex;
            if (PLC_CYCLE_DONE) pcnt = P;
            else if (pcnt > 0) pcnt = pcnt - 1;
        end
    end

    task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("Error %s expected %0h seen %0h", nm, e, s);
        end
    endtask

    always @(negedge CLK) if (go) chk("TERM_OUT", 32'(TERM_OUT), 32'(ex));
    // The driver pins repeat the terminal states one edge later.
    always @(negedge CLK) if (go) chk("pin", 32'(pin), 32'(exd));

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic rnd(int n);
        logic [31:0] r;
        repeat (n) begin
            @(posedge CLK);
            for (int i = 0; i < 25; i++) begin
                r = $random(seed);
                vals[i] <= {13'h0000, r[2:0]};
            end
            r = $random(seed);
            flg <= r[15:0];
            LOW_FUNC_COND <= r[24:16];
            COMM_TERM_VALUE <= r[29:25];
            PLC_CYCLE_DONE <= &{r[31:30], r[3:2]};
            r = $random(seed);
            TERM_SEL <= r[29:0];
        end
    endtask

    task automatic pulse_at(int gap);
        int n;
        @(posedge CLK);
        PLC_CYCLE_DONE <= 1'b1;
        @(posedge CLK);
        PLC_CYCLE_DONE <= 1'b0;
        if (gap > 0) begin
            repeat (gap - 1) @(posedge CLK);
            PLC_CYCLE_DONE <= 1'b1;
            @(posedge CLK);
            PLC_CYCLE_DONE <= 1'b0;
        end
        n = 0;
        while (TERM_OUT[0] !== 1'b1 && n < 100) begin @(negedge CLK); n++; end
        while (TERM_OUT[0] !== 1'b0 && n < 100) begin @(negedge CLK); n++; end
        if (n >= 100) begin
            miscompares++;
            $display("Error TERM_OUT[0] expected 0 seen %b", TERM_OUT[0]);
        end else begin
            @(negedge CLK);
            chk("pulse width", hi_len, 32'(P + gap));
        end
    endtask

    initial begin
        RESETN = 1'b0;
        go = 0;
        PLC_CYCLE_DONE = 1'b0;
        flg = '0;
        vals = '0;
        TERM_SEL = '0;
        LOW_FUNC_COND = '0;
        COMM_TERM_VALUE = '0;
        @(posedge CLK);
        go = 1;
        repeat (5) @(posedge CLK);
        RESETN <= 1'b1;
        rnd(3000);
        $display("random traffic done, checks %0d", n_checks);
        @(posedge CLK);
        RESETN <= 1'b0;
        rnd(2);
        @(posedge CLK);
        RESETN <= 1'b1;
        rnd(500);
        $display("mid-run reset done, checks %0d", n_checks);
        @(posedge CLK);
        TERM_SEL <= {5{6'h0B}};
        PLC_CYCLE_DONE <= 1'b0;
        repeat (30) @(posedge CLK);
        pulse_at(0);
        pulse_at(5);
        $display("cycle pulse done, checks %0d", n_checks);
        close_out;
    end
endmodule // tb
`default_nettype wire
